// *** logic/splwd_defs.vh ***
// Constants shared by the split-port link watchdog: register indexes, reset values,
// field positions, timeout table and link state codes.
// Assumes inclusion by bare name from the design files of this block.
`ifndef SPLWD_DEFS_VH
`define SPLWD_DEFS_VH

// Register indexes; the byte address on the bus is four times the index.
`define SPLWD_IDX_SPLIT_EN 30'h0000_3c48
`define SPLWD_IDX_GLOBAL_EN 30'h0000_4141
`define SPLWD_IDX_TIMEOUT_SEL 30'h0000_4171
`define SPLWD_IDX_OFF_DUR 30'h0000_4176
`define SPLWD_IDX_STATUS 30'h0000_4180

// Reset values.
`define SPLWD_RST_SPLIT_EN 7'h00
`define SPLWD_RST_GLOBAL_EN 1'h0
`define SPLWD_RST_TIMEOUT_SEL 3'h5
`define SPLWD_RST_OFF_DUR 8'h05

// Field positions.
`define SPLWD_SPLIT_EN_LSB 1
`define SPLWD_SPLIT_EN_MSB 7
`define SPLWD_SPLIT_EN_P5 5
`define SPLWD_SPLIT_EN_P6 6
`define SPLWD_GLOBAL_EN_BIT 0
`define SPLWD_TIMEOUT_MSB 2
`define SPLWD_REG_MSB 7
`define SPLWD_IDX_LSB 2

// Status field positions.
`define SPLWD_ST_P5_PWR 0
`define SPLWD_ST_P6_PWR 1
`define SPLWD_ST_P5_PULSE 2
`define SPLWD_ST_P6_PULSE 3
`define SPLWD_ST_P5_LS_LSB 4
`define SPLWD_ST_P5_LS_MSB 7
`define SPLWD_ST_P6_LS_LSB 8
`define SPLWD_ST_P6_LS_MSB 11

// Timeout selection codes and their durations in ms.
`define SPLWD_TO_OFF 3'h0
`define SPLWD_TO_C1 3'h1
`define SPLWD_TO_C2 3'h2
`define SPLWD_TO_C3 3'h3
`define SPLWD_TO_C4 3'h4
`define SPLWD_TO_C5 3'h5
`define SPLWD_TO_C6 3'h6
`define SPLWD_TO_MS_NONE 12'h000
`define SPLWD_TO_MS_C1 12'h064
`define SPLWD_TO_MS_C2 12'h0fa
`define SPLWD_TO_MS_C3 12'h1f4
`define SPLWD_TO_MS_C4 12'h2ee
`define SPLWD_TO_MS_C5 12'h3e8
`define SPLWD_TO_MS_C6 12'h7d0

// Off pulse length: base plus step per unit, in ms.
`define SPLWD_OFF_BASE_MS 12'h15e
`define SPLWD_OFF_STEP_MS 12'h00a

// Millisecond tick: clock rate in kHz and tick period in ms.
`define SPLWD_CLK_KHZ 25000
`define SPLWD_TICK_MS 1

// Link state codes that count as stuck when held.
`define SPLWD_LS_DISABLED 4'h4
`define SPLWD_LS_RXDETECT 4'h5
`define SPLWD_LS_INACTIVE 4'h6
`define SPLWD_LS_POLLING 4'h7
`define SPLWD_LS_RECOVERY 4'h8
`define SPLWD_LS_HOTRESET 4'h9

// Bus answers.
`define SPLWD_RESP_OKAY 2'h0
`define SPLWD_RESP_SLVERR 2'h2

`endif

// *** logic/splwd_port.v ***
// One split port's link watchdog: stuck-link timer and power-off pulse timer.
// Assumes a one-cycle millisecond tick and settings already decoded to ms.
`timescale 1ns/1ps
`include "splwd_defs.vh"

module splwd_port (
	input wire aclk,
	input wire aresetn,
	input wire ms_tick,
	input wire enable,
	input wire [11:0] timeout_ms,
	input wire [11:0] off_ms,
	input wire [3:0] link_state_status,
	output reg split_superspeed_power_out,
	output reg pulsing
);

	reg [3:0] prev_state_q;
	reg [11:0] to_cnt_q;
	reg [11:0] off_cnt_q;
	wire stuck;
	wire same;

	assign stuck = (link_state_status == `SPLWD_LS_DISABLED) || (link_state_status == `SPLWD_LS_RXDETECT) ||
		(link_state_status == `SPLWD_LS_INACTIVE) || (link_state_status == `SPLWD_LS_POLLING) ||
		(link_state_status == `SPLWD_LS_RECOVERY) || (link_state_status == `SPLWD_LS_HOTRESET);
	assign same = (link_state_status == prev_state_q);

	always @(posedge aclk) begin
		if (!aresetn) begin
			prev_state_q <= 4'h0;
			to_cnt_q <= 12'h000;
			off_cnt_q <= 12'h000;
			split_superspeed_power_out <= 1'b1;
			pulsing <= 1'b0;
		end else begin
			prev_state_q <= link_state_status;
			if (pulsing) begin
				// A pulse once started ignores enable and link state; only a shorter off duration written meanwhile cuts its off time short.
				if (ms_tick) begin
					if (off_cnt_q + 12'h001 >= off_ms) begin
						pulsing <= 1'b0;
						split_superspeed_power_out <= 1'b1;
						off_cnt_q <= 12'h000;
						to_cnt_q <= 12'h000;
					end else begin
						off_cnt_q <= off_cnt_q + 12'h001;
					end
				end
			end else if (!enable || !stuck || !same) begin
				to_cnt_q <= 12'h000;
			end else if (ms_tick) begin
				if (to_cnt_q + 12'h001 >= timeout_ms) begin
					to_cnt_q <= 12'h000;
					pulsing <= 1'b1;
					split_superspeed_power_out <= 1'b0;
				end else begin
					to_cnt_q <= to_cnt_q + 12'h001;
				end
			end
		end
	end

endmodule // splwd_port

// *** logic/splwd_top.v ***
// Split-port link watchdog for the SuperSpeed halves of downstream ports 5 and 6,
// with its configuration registers on an AXI4-Lite slave.
// Assumes link state codes synchronous to aclk and a single 25 MHz clock.
// Settings are used live, so a change written during a count takes effect at once.
`timescale 1ns/1ps
`include "splwd_defs.vh"

module splwd_top #(
	parameter MS_CYCLES = `SPLWD_CLK_KHZ * `SPLWD_TICK_MS
) (
	input wire aclk,
	input wire aresetn,
	input wire [31:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [31:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire [3:0] p5_link_state_status,
	input wire [3:0] p6_link_state_status,
	output wire p5_split_superspeed_power_out,
	output wire p6_split_superspeed_power_out
);

	// The divider is 15 bits wide, so MS_CYCLES above 32768 would wrap and shorten every time.
	localparam integer TICK_LAST_FULL = MS_CYCLES - 1;
	localparam [14:0] TICK_LAST = TICK_LAST_FULL[14:0];

	// Configuration state.
	reg [6:0] per_port_split_enable_q;
	reg global_split_enable_q;
	reg [2:0] timeout_sel_q;
	reg [7:0] off_dur_q;

	// Write channel bookkeeping.
	reg aw_have_q;
	reg w_have_q;
	reg [29:0] aw_idx_q;
	reg [31:0] w_data_q;
	reg w_lane0_q;

	// Millisecond divider.
	reg [14:0] div_q;
	reg ms_tick_q;

	wire p5_pulsing;
	wire p6_pulsing;
	reg [11:0] timeout_ms;
	wire [11:0] off_ms;
	wire [11:0] off_ext;
	wire p5_enable;
	wire p6_enable;
	reg [31:0] rd_mux;
	reg rd_hit;
	wire [29:0] ar_idx;
	wire [`SPLWD_ST_P6_LS_MSB:0] status_word;
	reg wr_commit;
	reg wr_known;
	reg wr_split_en;
	reg wr_global_en;
	reg wr_timeout_sel;
	reg wr_off_dur;

	// Timeout code to duration; code seven is reserved and treated as off so it can never pulse early.
	always @* begin
		case (timeout_sel_q)
			`SPLWD_TO_C1: timeout_ms = `SPLWD_TO_MS_C1;
			`SPLWD_TO_C2: timeout_ms = `SPLWD_TO_MS_C2;
			`SPLWD_TO_C3: timeout_ms = `SPLWD_TO_MS_C3;
			`SPLWD_TO_C4: timeout_ms = `SPLWD_TO_MS_C4;
			`SPLWD_TO_C5: timeout_ms = `SPLWD_TO_MS_C5;
			`SPLWD_TO_C6: timeout_ms = `SPLWD_TO_MS_C6;
			default: timeout_ms = `SPLWD_TO_MS_NONE;
		endcase
	end

	assign off_ext = {4'h0, off_dur_q};
	assign off_ms = `SPLWD_OFF_BASE_MS + off_ext * `SPLWD_OFF_STEP_MS;

	// Both enables and a valid timeout code are needed before a port is watched.
	assign p5_enable = global_split_enable_q && per_port_split_enable_q[`SPLWD_SPLIT_EN_P5 - `SPLWD_SPLIT_EN_LSB] &&
		(timeout_ms != `SPLWD_TO_MS_NONE);
	assign p6_enable = global_split_enable_q && per_port_split_enable_q[`SPLWD_SPLIT_EN_P6 - `SPLWD_SPLIT_EN_LSB] &&
		(timeout_ms != `SPLWD_TO_MS_NONE);

	always @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= 15'h0000;
			ms_tick_q <= 1'b0;
		end else if (div_q >= TICK_LAST) begin
			div_q <= 15'h0000;
			ms_tick_q <= 1'b1;
		end else begin
			div_q <= div_q + 15'h0001;
			ms_tick_q <= 1'b0;
		end
	end

	// Separate instances keep a stuck port from disturbing the other one.
	splwd_port u_port5 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ms_tick(ms_tick_q),
		.enable(p5_enable),
		.timeout_ms(timeout_ms),
		.off_ms(off_ms),
		.link_state_status(p5_link_state_status),
		.split_superspeed_power_out(p5_split_superspeed_power_out),
		.pulsing(p5_pulsing)
	);

	splwd_port u_port6 (
		.aclk(aclk),
		.aresetn(aresetn),
		.ms_tick(ms_tick_q),
		.enable(p6_enable),
		.timeout_ms(timeout_ms),
		.off_ms(off_ms),
		.link_state_status(p6_link_state_status),
		.split_superspeed_power_out(p6_split_superspeed_power_out),
		.pulsing(p6_pulsing)
	);

	// Write path: address and data are accepted in either order, then answered together.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `SPLWD_RESP_OKAY;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_idx_q <= 30'h0000_0000;
			w_data_q <= 32'h0000_0000;
			w_lane0_q <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_idx_q <= s_axi_awaddr[31:`SPLWD_IDX_LSB];
				aw_have_q <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_q <= s_axi_wdata;
				w_lane0_q <= s_axi_wstrb[0];
				w_have_q <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (wr_commit) begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Unmapped writes are refused with an error and leave every setting untouched.
				s_axi_bresp <= wr_known ? `SPLWD_RESP_OKAY : `SPLWD_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Write decode: one strobe per writable register, raised in the cycle the write commits.
	always @* begin
		wr_commit = aw_have_q && w_have_q && !s_axi_bvalid;
		wr_known = 1'b1;
		wr_split_en = 1'b0;
		wr_global_en = 1'b0;
		wr_timeout_sel = 1'b0;
		wr_off_dur = 1'b0;
		case (aw_idx_q)
			`SPLWD_IDX_SPLIT_EN: begin
				wr_split_en = wr_commit && w_lane0_q;
			end
			`SPLWD_IDX_GLOBAL_EN: begin
				wr_global_en = wr_commit && w_lane0_q;
			end
			`SPLWD_IDX_TIMEOUT_SEL: begin
				wr_timeout_sel = wr_commit && w_lane0_q;
			end
			`SPLWD_IDX_OFF_DUR: begin
				wr_off_dur = wr_commit && w_lane0_q;
			end
			`SPLWD_IDX_STATUS: begin
				wr_known = 1'b1;
			end
			default: begin
				wr_known = 1'b0;
			end
		endcase
	end

	// All writable registers are one byte wide, so only lane zero carries data.
	always @(posedge aclk) begin
		if (!aresetn) begin
			per_port_split_enable_q <= `SPLWD_RST_SPLIT_EN;
			global_split_enable_q <= `SPLWD_RST_GLOBAL_EN;
			timeout_sel_q <= `SPLWD_RST_TIMEOUT_SEL;
			off_dur_q <= `SPLWD_RST_OFF_DUR;
		end else begin
			if (wr_split_en) begin
				per_port_split_enable_q <= w_data_q[`SPLWD_SPLIT_EN_MSB:`SPLWD_SPLIT_EN_LSB];
			end
			if (wr_global_en) begin
				global_split_enable_q <= w_data_q[`SPLWD_GLOBAL_EN_BIT];
			end
			if (wr_timeout_sel) begin
				timeout_sel_q <= w_data_q[`SPLWD_TIMEOUT_MSB:0];
			end
			if (wr_off_dur) begin
				off_dur_q <= w_data_q[`SPLWD_REG_MSB:0];
			end
		end
	end

	// Status is read-only and gathers each port's live power, pulse and link state.
	assign status_word[`SPLWD_ST_P5_PWR] = p5_split_superspeed_power_out;
	assign status_word[`SPLWD_ST_P6_PWR] = p6_split_superspeed_power_out;
	assign status_word[`SPLWD_ST_P5_PULSE] = p5_pulsing;
	assign status_word[`SPLWD_ST_P6_PULSE] = p6_pulsing;
	assign status_word[`SPLWD_ST_P5_LS_MSB:`SPLWD_ST_P5_LS_LSB] = p5_link_state_status;
	assign status_word[`SPLWD_ST_P6_LS_MSB:`SPLWD_ST_P6_LS_LSB] = p6_link_state_status;

	assign ar_idx = s_axi_araddr[31:`SPLWD_IDX_LSB];

	always @* begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (ar_idx)
			`SPLWD_IDX_SPLIT_EN: begin
				rd_mux[`SPLWD_SPLIT_EN_MSB:`SPLWD_SPLIT_EN_LSB] = per_port_split_enable_q;
			end
			`SPLWD_IDX_GLOBAL_EN: begin
				rd_mux[`SPLWD_GLOBAL_EN_BIT] = global_split_enable_q;
			end
			`SPLWD_IDX_TIMEOUT_SEL: begin
				rd_mux[`SPLWD_TIMEOUT_MSB:0] = timeout_sel_q;
			end
			`SPLWD_IDX_OFF_DUR: begin
				rd_mux[`SPLWD_REG_MSB:0] = off_dur_q;
			end
			`SPLWD_IDX_STATUS: begin
				rd_mux[`SPLWD_ST_P6_LS_MSB:0] = status_word;
			end
			default: begin
				// Unmapped reads return zero with an error answer.
				rd_hit = 1'b0;
			end
		endcase
	end

	// Read path: one read at a time, answered the cycle after the address is taken.
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `SPLWD_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? `SPLWD_RESP_OKAY : `SPLWD_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule // splwd_top

// *** verif/splwd_dev.sv ***
// Behavioural power switch and embedded device on one split port.
// Assumes the power output is high while the device is powered.
`timescale 1ns/1ps
module splwd_dev (
	input logic aclk,
	input logic power,
	input logic hang,
	output logic [3:0] link_state_status = 4'h0
);
	// An unpowered device shows receiver detect; a hung one sits in polling.
	always @(posedge aclk) begin
		link_state_status <= !power ? 4'h5 : hang ? 4'h7 : 4'h0;
	end
endmodule // splwd_dev

// *** verif/splwd_properties.sv ***
// Bus and power pulse assertions for the split-port watchdog top.
// Assumes binding to splwd_top and a synchronous active-low reset.
`timescale 1ns/1ps
module splwd_props (
	input logic aclk,
	input logic aresetn,
	input logic s_axi_awready,
	input logic s_axi_wready,
	input logic s_axi_bvalid,
	input logic s_axi_bready,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid,
	input logic s_axi_rready,
	input logic [3:0] p5_link_state_status,
	input logic [3:0] p6_link_state_status,
	input logic p5_split_superspeed_power_out,
	input logic p6_split_superspeed_power_out
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("Write answer dropped early.");
	write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("Write accepted while answer pending.");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("Read answer dropped early.");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("Read not answered one cycle later.");
	p5_stuck_fall_a: assert property ($fell(p5_split_superspeed_power_out) |->
		$past(p5_link_state_status) inside {[4'h4:4'h9]} && $past(p5_link_state_status) == $past(p5_link_state_status, 2))
		else $error("Port 5 power cut without a stuck link.");
	p5_pulse_min_a: assert property ($fell(p5_split_superspeed_power_out) |=> !p5_split_superspeed_power_out [*8])
		else $error("Port 5 pulse too short.");
	p6_stuck_fall_a: assert property ($fell(p6_split_superspeed_power_out) |->
		$past(p6_link_state_status) inside {[4'h4:4'h9]} && $past(p6_link_state_status) == $past(p6_link_state_status, 2))
		else $error("Port 6 power cut without a stuck link.");
	p6_pulse_min_a: assert property ($fell(p6_split_superspeed_power_out) |=> !p6_split_superspeed_power_out [*8])
		else $error("Port 6 pulse too short.");
endmodule // splwd_props
bind splwd_top splwd_props chk_u (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .p5_link_state_status, .p6_link_state_status,
	.p5_split_superspeed_power_out, .p6_split_superspeed_power_out);

// *** verif/splwd_top_tb.sv ***
// Self-checking bench for splwd_top: AXI4-Lite master and two device models.
// Assumes a shortened millisecond of MS clock cycles.
`timescale 1ns/1ps
module splwd_top_tb;
	localparam int MS = 2;
	localparam logic [31:0] A_EN = 32'h0000_f120, A_GL = 32'h0001_0504;
	localparam logic [31:0] A_TO = 32'h0001_05c4, A_OFF = 32'h0001_05d8, A_ST = 32'h0001_0600;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0] hang = 2'h0;
	logic [3:0] wstrb = 4'hf;
	wire awready, wready, bvalid, arready, rvalid;
	wire [1:0] bresp, rresp, pw;
	wire [31:0] rdata;
	wire [3:0] ls5, ls6;
	int fails = 0, checks_done = 0;
	int tms [7] = '{0, 100, 250, 500, 750, 1000, 2000};
	always #20 aclk = ~aclk;
	splwd_top #(.MS_CYCLES(MS)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.p5_link_state_status(ls5), .p6_link_state_status(ls6),
		.p5_split_superspeed_power_out(pw[0]), .p6_split_superspeed_power_out(pw[1])
	);
	splwd_dev dev5_u (.aclk(aclk), .power(pw[0]), .hang(hang[0]), .link_state_status(ls5));
	splwd_dev dev6_u (.aclk(aclk), .power(pw[1]), .hang(hang[1]), .link_state_status(ls6));
	task automatic chk(input logic [31:0] s, e);
		checks_done++;
		if (s !== e) begin
			fails++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic lim(input bit bad);
		if (bad) begin
			fails++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
		int i;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		bready <= 1'b0;
		lim(i >= 200);
		chk(bresp, r);
	endtask
	task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
		int i;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		rready <= 1'b0;
		lim(i >= 200);
		chk(rdata, d);
		chk(rresp, r);
	endtask
	task automatic wt(input int p, input logic v, output int n);
		for (n = 0; n < 9000 && pw[p] !== v; n++) @(posedge aclk);
		lim(n >= 9000);
	endtask
	// The first timeout may run up to one tick short, so timeouts get a tick plus four cycles of slack.
	function automatic logic near(int c, e, tol);
		return c >= e - tol && c <= e + tol;
	endfunction
	task automatic t_regs();
		rd(A_EN, 32'h0, 2'h0);
		rd(A_GL, 32'h0, 2'h0);
		rd(A_TO, 32'h5, 2'h0);
		rd(A_OFF, 32'h5, 2'h0);
		wr(A_ST, 32'hfff, 2'h0);
		rd(A_ST, 32'h3, 2'h0);
		rd(32'h100, 32'h0, 2'h2);
		wr(32'h100, 32'h1, 2'h2);
		wr(A_TO, 32'hff, 2'h0);
		rd(A_TO, 32'h7, 2'h0);
		wr(A_EN, 32'hff, 2'h0);
		rd(A_EN, 32'hfe, 2'h0);
		wr(A_OFF, 32'hff, 2'h0);
		rd(A_OFF, 32'hff, 2'h0);
		wstrb <= 4'he;
		wr(A_OFF, 32'h11, 2'h0);
		rd(A_OFF, 32'hff, 2'h0);
		wstrb <= 4'hf;
	endtask
	task automatic t_gate();
		hang <= 2'h3;
		wr(A_EN, 32'h60, 2'h0);
		wr(A_TO, 32'h1, 2'h0);
		repeat (400) @(posedge aclk);
		chk(pw, 2'h3);
		wr(A_TO, 32'h0, 2'h0);
		wr(A_GL, 32'h1, 2'h0);
		repeat (400) @(posedge aclk);
		chk(pw, 2'h3);
		hang <= 2'h0;
	endtask
	task automatic run(input int p, c, n);
		int t;
		wr(A_TO, c, 2'h0);
		wr(A_OFF, n, 2'h0);
		hang[p] <= 1'b1;
		wt(p, 1'b0, t);
		chk(near(t, tms[c] * MS, MS + 4), 1'b1);
		chk(pw[1 - p], 1'b1);
		wt(p, 1'b1, t);
		chk(near(t, (350 + 10 * n) * MS, 2), 1'b1);
		wt(p, 1'b0, t);
		chk(near(t, tms[c] * MS, MS + 4), 1'b1);
		hang[p] <= 1'b0;
		rd(A_ST, p == 0 ? 32'h056 : 32'h509, 2'h0);
		wt(p, 1'b1, t);
	endtask
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_gate();
		for (int c = 1; c < 7; c++) run(0, c, c);
		run(1, 1, 0);
		tally_and_finish();
	end
endmodule // splwd_top_tb
